//--- logic/mac_screen_tx.v
`timescale 1ns/100ps
`include "mac_screen_tx_defines.vh"
module mac_screen_tx #(
    parameter NQ = 4,
    parameter NSCR = 4
) (
    // Clock and reset
    input wire clock,
    input wire srst,
    // Events: DMA per queue, other MAC events
    input wire [NQ-1:0] dma_event,
    input wire mac_event,
    input wire prio_queue_en,
    input wire [NQ-1:0] isr_clear,
    // Receive stream after address filter
    input wire rx_frame_start,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_addr_match,
    input wire rx_frame_end,
    input wire [10:0] rx_etype_end,
    input wire [10:0] rx_ip_end,
    input wire [10:0] rx_l4_end,
    input wire rx_ip_fragment,
    // Screener configuration, flattened per screener
    input wire [NSCR*3-1:0] screen_en,
    input wire [NSCR*15-1:0] screen_sel,
    input wire [NSCR*2-1:0] screen_queue,
    // Compare entry pool
    input wire [`CW_POOL_SIZE*7-1:0] cw_position,
    input wire [`CW_POOL_SIZE*2-1:0] cw_origin,
    input wire [`CW_POOL_SIZE*16-1:0] cw_value,
    input wire [`CW_POOL_SIZE*16-1:0] cw_mask,
    // Transmit FIFO side
    input wire tx_word_valid,
    input wire [31:0] tx_word,
    input wire [1:0] tx_word_bytes,
    input wire tx_word_last,
    output reg tx_word_ready_q,
    input wire full_duplex,
    // MII
    input wire mii_tx_clk,
    input wire mii_crs,
    input wire mii_col,
    output reg [3:0] mii_txd_q,
    output reg mii_tx_en_q,
    // Status
    output reg [NQ-1:0] irq_q,
    output reg [NQ-1:0] isr_q,
    output reg route_valid_q,
    output reg [1:0] route_queue_q,
    output reg tx_busy_q,
    output reg tx_abort_q
);
    localparam S_IDLE = 3'h0, S_PRE = 3'h1, S_DATA = 3'h2, S_PAD = 3'h3, S_CRC = 3'h4, S_JAM = 3'h5,
        S_BACK = 3'h6, S_IFG = 3'h7;
    integer i, j, k;
    genvar g, u;

    // Interrupt status: bit 0 is the low-offset word, the rest follow the high base; set wins over clear. [RULE_03]
    always @(posedge clock) begin
        if (srst) begin
            isr_q <= {NQ{1'b0}};
            irq_q <= {NQ{1'b0}};
        end else begin
            for (i = 0; i < NQ; i = i + 1) begin
                if (prio_queue_en || i == 0) begin // [RULE_01]
                    if (dma_event[i] || (i == 0 && (mac_event || (!prio_queue_en && |dma_event)))) begin // [RULE_02]
                        isr_q[i] <= 1'b1;
                    end else if (isr_clear[i]) begin
                        isr_q[i] <= 1'b0;
                    end
                end else begin
                    isr_q[i] <= 1'b0;
                end
            end
            irq_q <= isr_q;
        end
    end

    // Screeners.
    wire [NSCR*3-1:0] unit_hit;
    generate
        for (g = 0; g < NSCR; g = g + 1) begin : scr
            for (u = 0; u < 3; u = u + 1) begin : cu
                wire [4:0] sel = screen_sel[(g*3+u)*5 +: 5]; // [RULE_05]
                wire [4:0] ent = (sel < `CW_POOL_SIZE) ? sel : 5'h00; // [RULE_10]
                wire [1:0] org = cw_origin[ent*2 +: 2];
                reg [10:0] base;
                always @* begin
                    case (org) // [RULE_08] [RULE_09]
                        `ORG_FRAME: base = 11'h000;
                        `ORG_ETYPE: base = rx_etype_end;
                        `ORG_IP: base = rx_ip_end;
                        `ORG_L4: base = rx_l4_end;
                        default: base = 11'h000;
                    endcase
                end
                screen_compare cmp (
                    .clock(clock),
                    .srst(srst),
                    .frame_start(rx_frame_start),
                    .byte_valid(rx_byte_valid),
                    .byte_data(rx_byte),
                    .origin_index(base),
                    .byte_position(cw_position[ent*7 +: 7]),
                    .reference_value(cw_value[ent*16 +: 16]),
                    .select_mask(cw_mask[ent*16 +: 16]),
                    .hit_q(unit_hit[g*3+u])
                );
            end
        end
    endgenerate

    reg found;
    reg [1:0] found_q;
    always @* begin
        found = 1'b0;
        found_q = 2'h0;
        for (j = NSCR - 1; j >= 0; j = j - 1) begin
            if (|screen_en[j*3 +: 3] && ((unit_hit[j*3 +: 3] | ~screen_en[j*3 +: 3]) == 3'h7)
                && !(rx_ip_fragment && |cw_origin)) begin // [RULE_11]
                found = 1'b1;
                found_q = screen_queue[j*2 +: 2];
            end
        end
    end
    always @(posedge clock) begin
        if (srst) begin
            route_valid_q <= 1'b0;
            route_queue_q <= 2'h0;
        end else begin
            route_valid_q <= rx_frame_end && rx_addr_match; // [RULE_04]
            route_queue_q <= (rx_frame_end && rx_addr_match && found) ? found_q : 2'h0; // [RULE_18]
        end
    end

    // MII clock passes three flip-flops, carrier and collision two.
    reg [2:0] clk_s;
    reg [1:0] crs_s, col_s;
    always @(posedge clock) begin
        if (srst) begin
            clk_s <= 3'h0;
            crs_s <= 2'h0;
            col_s <= 2'h0;
        end else begin
            clk_s <= {clk_s[1:0], mii_tx_clk};
            crs_s <= {crs_s[0], mii_crs};
            col_s <= {col_s[0], mii_col};
        end
    end
    wire tick = clk_s[2] && !clk_s[1];
    wire crs = crs_s[1];
    wire col = col_s[1];

    // Transmitter.
    reg [2:0] st_q;
    reg [31:0] buf_q;
    reg [1:0] bufn_q;
    reg buf_v_q, buf_last_q, nib_q;
    reg [1:0] bidx_q;
    reg [10:0] len_q;
    reg [31:0] crc_q;
    reg [9:0] cnt_q;
    reg [4:0] att_q;
    reg [15:0] lfsr_q;
    reg [7:0] cur;
    reg [31:0] crc_n;
    always @* begin
        cur = buf_q[bidx_q*8 +: 8];
        if (st_q == S_PAD) cur = 8'h00;
        crc_n = crc_q;
        for (k = 0; k < 8; k = k + 1) begin
            crc_n = (crc_n[0] ^ cur[k]) ? ((crc_n >> 1) ^ `CRC_POLY_REV) : (crc_n >> 1); // [RULE_16]
        end
    end
    wire [7:0] crc_byte = ~crc_q[len_q[1:0]*8 +: 8];
    wire [7:0] sfd_byte = `SFD_BYTE;
    wire [7:0] pre_byte = `PREAMBLE_BYTE;
    wire coll = !full_duplex && col && (st_q == S_PRE || st_q == S_DATA || st_q == S_PAD); // [RULE_12]

    always @(posedge clock) begin
        if (srst) begin
            st_q <= S_IDLE;
            buf_q <= 32'h0;
            bufn_q <= 2'h0;
            buf_v_q <= 1'b0;
            buf_last_q <= 1'b0;
            nib_q <= 1'b0;
            bidx_q <= 2'h0;
            len_q <= 11'h000;
            crc_q <= `CRC_INIT;
            cnt_q <= 10'h000;
            att_q <= 5'h00;
            lfsr_q <= 16'hACE1;
            tx_word_ready_q <= 1'b0;
            mii_txd_q <= 4'h0;
            mii_tx_en_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_abort_q <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            tx_abort_q <= 1'b0;
            tx_word_ready_q <= !buf_v_q && !tx_word_ready_q && (st_q == S_IDLE || st_q == S_DATA);
            if (tx_word_ready_q && tx_word_valid) begin // [RULE_13]
                buf_q <= tx_word;
                bufn_q <= tx_word_bytes;
                buf_last_q <= tx_word_last;
                buf_v_q <= 1'b1;
                bidx_q <= 2'h0;
            end
            tx_busy_q <= st_q != S_IDLE;
            if (coll) begin
                st_q <= S_JAM;
                cnt_q <= {6'h00, `JAM_NIBBLES};
                mii_txd_q <= 4'h5;
            end else if (tick) begin
                case (st_q)
                    S_IDLE: begin
                        mii_tx_en_q <= 1'b0;
                        if (buf_v_q && (full_duplex || !crs)) begin
                            st_q <= S_PRE;
                            cnt_q <= 10'h000;
                            crc_q <= `CRC_INIT;
                            len_q <= 11'h000;
                        end
                    end
                    S_PRE: begin
                        mii_tx_en_q <= 1'b1;
                        mii_txd_q <= (cnt_q == 10'h00F) ? sfd_byte[7:4] : pre_byte[3:0]; // [RULE_14]
                        cnt_q <= cnt_q + 10'h001;
                        if (cnt_q == 10'h00F) begin
                            st_q <= S_DATA;
                            nib_q <= 1'b0;
                        end
                    end
                    S_DATA, S_PAD: begin
                        if (st_q == S_PAD || buf_v_q) begin
                            mii_txd_q <= nib_q ? cur[7:4] : cur[3:0]; // [RULE_17]
                            nib_q <= !nib_q;
                            if (nib_q) begin
                                crc_q <= crc_n;
                                len_q <= len_q + 11'h001;
                                if (st_q == S_DATA) begin
                                    bidx_q <= bidx_q + 2'h1;
                                    if (bidx_q == bufn_q) begin
                                        buf_v_q <= 1'b0;
                                        if (buf_last_q) begin
                                            st_q <= (len_q + 11'h001 < `MIN_FRAME_LEN) ? S_PAD : S_CRC; // [RULE_15]
                                        end
                                    end
                                end else if (len_q + 11'h001 >= `MIN_FRAME_LEN) begin
                                    st_q <= S_CRC; // [RULE_15]
                                end
                                if (st_q == S_DATA && bidx_q == bufn_q && buf_last_q
                                    && len_q + 11'h001 >= `MIN_FRAME_LEN) begin
                                    len_q <= 11'h000;
                                end else if (st_q == S_PAD && len_q + 11'h001 >= `MIN_FRAME_LEN) begin
                                    len_q <= 11'h000;
                                end
                            end
                        end
                    end
                    S_CRC: begin
                        mii_txd_q <= nib_q ? crc_byte[7:4] : crc_byte[3:0]; // [RULE_16]
                        nib_q <= !nib_q;
                        if (nib_q) begin
                            len_q <= len_q + 11'h001;
                            if (len_q[1:0] == 2'h3) begin
                                st_q <= S_IFG;
                                cnt_q <= {4'h0, `IFG_NIBBLES};
                                att_q <= 5'h00;
                            end
                        end
                    end
                    S_JAM: begin
                        cnt_q <= cnt_q - 10'h001;
                        if (cnt_q == 10'h001) begin
                            mii_tx_en_q <= 1'b0;
                            att_q <= att_q + 5'h01;
                            if (att_q + 5'h01 >= `MAX_ATTEMPTS) begin
                                st_q <= S_IFG;
                                cnt_q <= {4'h0, `IFG_NIBBLES};
                                buf_v_q <= 1'b0;
                                tx_abort_q <= 1'b1;
                            end else begin
                                st_q <= S_BACK;
                                cnt_q <= lfsr_q[9:0] & ((10'h001 << att_q) - 10'h001); // [RULE_12]
                            end
                        end
                    end
                    S_BACK: begin
                        mii_tx_en_q <= 1'b0;
                        if (cnt_q == 10'h000) begin
                            st_q <= S_IDLE;
                        end else begin
                            cnt_q <= cnt_q - 10'h001;
                        end
                    end
                    S_IFG: begin
                        mii_tx_en_q <= 1'b0;
                        cnt_q <= cnt_q - 10'h001;
                        if (cnt_q == 10'h001) st_q <= S_IDLE;
                    end
                    default: st_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule // mac_screen_tx

//--- logic/mac_screen_tx_defines.vh
// Summary of operation
// RULE_01: With priority queuing on, give one interrupt output and status per queue.
// RULE_02: Only DMA events go to per-queue interrupts; all others to lowest queue.
// RULE_03: Lowest queue status sits at 0x24; others consecutive from 0x400.
// RULE_04: Only frames passing address matching are evaluated by the screeners.
// RULE_05: Each screener has three compare units, each with enable and entry pointer.
// RULE_06: Enabled unit true when masked frame word equals masked reference value.
// RULE_07: Compare is 16-bit: offset byte against bits 7:0, next byte 15:8.
// RULE_08: Byte position 0..127 from frame start, after EtherType, IP or TCP/UDP header.
// RULE_09: IP and TCP/UDP header location reuses checksum decoding; no fragments.
// RULE_10: All compare units share one pool of 24 compare entries.
// RULE_11: Screener match is the AND of all its enabled compare units.
// RULE_12: Transmitter supports half and full duplex; half duplex uses CSMA/CD.
// RULE_13: Transmit data is fetched as 32-bit words, then handled byte by byte.
// RULE_14: Frame starts with preamble then start frame delimiter.
// RULE_15: Frames shorter than 60 bytes are padded to 60 before CRC.
// RULE_16: A 32-bit CRC is computed, inverted and appended.
// RULE_17: Assembled bytes are driven to the PHY over MII.
// RULE_18: A matching screener routes the frame to its configured queue.
`ifndef MAC_SCREEN_TX_DEFINES_VH
`define MAC_SCREEN_TX_DEFINES_VH
`define ISR_LOW_OFFSET 12'h024
`define ISR_HIGH_BASE 12'h400
`define CW_POOL_SIZE 24
`define POS_MAX 7'h7F
`define ORG_FRAME 2'h0
`define ORG_ETYPE 2'h1
`define ORG_IP 2'h2
`define ORG_L4 2'h3
`define PREAMBLE_BYTE 8'h55
`define SFD_BYTE 8'hD5
`define MIN_FRAME_LEN 11'h03C
`define CRC_INIT 32'hFFFFFFFF
`define CRC_POLY_REV 32'hEDB88320
`define JAM_NIBBLES 4'h8
`define IFG_NIBBLES 6'h18
`define SLOT_NIBBLES 10'h3FF
`define MAX_ATTEMPTS 5'h10
`endif

//--- logic/screen_compare.v
`timescale 1ns/100ps
`include "mac_screen_tx_defines.vh"
// One compare unit: picks its byte pair out of the received byte stream.
module screen_compare (
    // Clock and reset
    input wire clock,
    input wire srst,
    // Received frame stream
    input wire frame_start,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire [10:0] origin_index,
    // Selected compare entry
    input wire [6:0] byte_position,
    input wire [15:0] reference_value,
    input wire [15:0] select_mask,
    // Result
    output reg hit_q
);
    reg [10:0] idx_q;
    reg lo_ok_q;
    wire [10:0] target;
    assign target = origin_index + {4'h0, byte_position};
    always @(posedge clock) begin
        if (srst || frame_start) begin
            idx_q <= 11'h000;
            lo_ok_q <= 1'b0;
            hit_q <= 1'b0;
        end else if (byte_valid) begin
            idx_q <= idx_q + 11'h001;
            if (idx_q == target) begin
                lo_ok_q <= ((byte_data ^ reference_value[7:0]) & select_mask[7:0]) == 8'h00; // [RULE_07]
            end
            if (idx_q == target + 11'h001) begin
                hit_q <= lo_ok_q && (((byte_data ^ reference_value[15:8]) & select_mask[15:8]) == 8'h00); // [RULE_06]
            end
        end
    end
endmodule // screen_compare

//--- dv/mac_screen_tx_properties.sv
`timescale 1ns/100ps
module mac_screen_tx_properties #(
    parameter NQ = 4,
    parameter NSCR = 4
) (
    // Clock and reset
    input wire clock,
    input wire srst,
    // Watched inputs
    input wire [NQ-1:0] dma_event,
    input wire mac_event,
    input wire prio_queue_en,
    input wire rx_addr_match,
    input wire rx_frame_end,
    // Watched outputs
    input wire tx_word_ready_q,
    input wire [3:0] mii_txd_q,
    input wire mii_tx_en_q,
    input wire [NQ-1:0] irq_q,
    input wire [NQ-1:0] isr_q,
    input wire route_valid_q,
    input wire tx_busy_q
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    a_dma_own_queue: assert property (prio_queue_en && dma_event[NQ-1] |=> isr_q[NQ-1])
        else $error("DMA event missed its own queue status");
    a_mac_low_queue: assert property (mac_event |=> isr_q[0])
        else $error("MAC event missed lowest queue status");
    a_single_irq: assert property (!prio_queue_en && isr_q[NQ-1:1] == 0 |=> isr_q[NQ-1:1] == 0)
        else $error("Upper queue status set without priority queuing");
    a_irq_follows: assert property ($rose(isr_q[0]) |=> irq_q[0])
        else $error("Interrupt did not follow status");
    a_route_on_match: assert property (rx_frame_end && rx_addr_match |=> route_valid_q)
        else $error("No route after address match");
    a_route_cause: assert property (route_valid_q |-> $past(rx_frame_end && rx_addr_match))
        else $error("Route without address match");
    a_preamble_start: assert property ($rose(mii_tx_en_q) |-> (mii_tx_en_q && mii_txd_q == 4'h5) [*7])
        else $error("Frame did not open with a preamble nibble");
    a_ready_pulse: assert property (tx_word_ready_q |=> !tx_word_ready_q)
        else $error("Word ready stood longer than one cycle");
    a_enable_busy: assert property (mii_tx_en_q |-> tx_busy_q)
        else $error("Transmit enable while not busy");
endmodule // mac_screen_tx_properties
bind mac_screen_tx mac_screen_tx_properties #(.NQ(NQ), .NSCR(NSCR)) u_props (.clock(clock), .srst(srst),
    .dma_event(dma_event), .mac_event(mac_event), .prio_queue_en(prio_queue_en), .rx_addr_match(rx_addr_match),
    .rx_frame_end(rx_frame_end), .tx_word_ready_q(tx_word_ready_q), .mii_txd_q(mii_txd_q),
    .mii_tx_en_q(mii_tx_en_q), .irq_q(irq_q), .isr_q(isr_q), .route_valid_q(route_valid_q), .tx_busy_q(tx_busy_q));

//--- dv/mii_phy_model.sv
`timescale 1ns/100ps
module mii_phy_model (
    // Transmit side of the MII
    input wire [3:0] mii_txd_q,
    input wire mii_tx_en_q,
    // Line condition set by the bench
    input wire carrier,
    input wire collide,
    // Towards the MAC
    output reg mii_tx_clk,
    output wire mii_crs,
    output wire mii_col
);
    reg [7:0] rx_q [$];
    reg [3:0] low_q;
    reg phase_q;
    initial begin
        mii_tx_clk = 1'b0;
        phase_q = 1'b0;
        low_q = 4'h0;
        #137;
        forever #200 mii_tx_clk = ~mii_tx_clk;
    end
    // A half-duplex PHY also raises carrier while the MAC itself transmits.
    assign mii_crs = carrier | mii_tx_en_q;
    assign mii_col = collide & mii_tx_en_q;
    always @(posedge mii_tx_clk) begin
        if (!mii_tx_en_q) begin
            phase_q <= 1'b0;
        end else if (!phase_q) begin
            low_q <= mii_txd_q;
            phase_q <= 1'b1;
        end else begin
            rx_q.push_back({mii_txd_q, low_q});
            phase_q <= 1'b0;
        end
    end
endmodule // mii_phy_model

//--- dv/tb.sv
`timescale 1ns/100ps
module tb;
    reg clock = 1'b0;
    reg srst = 1'b1;
    reg [3:0] dma_event = 4'h0;
    reg mac_event = 1'b0;
    reg prio_queue_en = 1'b0;
    reg [3:0] isr_clear = 4'h0;
    reg rx_frame_start = 1'b0;
    reg rx_byte_valid = 1'b0;
    reg [7:0] rx_byte = 8'h00;
    reg rx_addr_match = 1'b0;
    reg rx_frame_end = 1'b0;
    reg [11:0] screen_en = 12'h000;
    reg [59:0] screen_sel = 60'h0;
    reg [7:0] screen_queue = 8'h00;
    reg [167:0] cw_position = 168'h0;
    reg [47:0] cw_origin = 48'h0;
    reg [383:0] cw_value = 384'h0;
    reg [383:0] cw_mask = 384'h0;
    reg tx_word_valid = 1'b0;
    reg [31:0] tx_word = 32'h0;
    reg [1:0] tx_word_bytes = 2'h0;
    reg tx_word_last = 1'b0;
    reg full_duplex = 1'b1;
    reg carrier = 1'b0;
    reg collide = 1'b0;
    reg rx_ip_fragment = 1'b0;
    wire tx_abort_q;
    wire tx_word_ready_q, mii_tx_clk, mii_crs, mii_col, mii_tx_en_q, route_valid_q, tx_busy_q;
    wire [3:0] mii_txd_q, irq_q, isr_q;
    wire [1:0] route_queue_q;
    integer failures = 0;
    integer cmp_count = 0;
    mac_screen_tx #(.NQ(4), .NSCR(4)) uut (.clock(clock), .srst(srst), .dma_event(dma_event),
        .mac_event(mac_event), .prio_queue_en(prio_queue_en), .isr_clear(isr_clear),
        .rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
        .rx_addr_match(rx_addr_match), .rx_frame_end(rx_frame_end), .rx_etype_end(11'h00E),
        .rx_ip_end(11'h022), .rx_l4_end(11'h036), .rx_ip_fragment(rx_ip_fragment), .screen_en(screen_en),
        .screen_sel(screen_sel), .screen_queue(screen_queue), .cw_position(cw_position), .cw_origin(cw_origin),
        .cw_value(cw_value), .cw_mask(cw_mask), .tx_word_valid(tx_word_valid), .tx_word(tx_word),
        .tx_word_bytes(tx_word_bytes), .tx_word_last(tx_word_last), .tx_word_ready_q(tx_word_ready_q),
        .full_duplex(full_duplex), .mii_tx_clk(mii_tx_clk), .mii_crs(mii_crs), .mii_col(mii_col),
        .mii_txd_q(mii_txd_q), .mii_tx_en_q(mii_tx_en_q), .irq_q(irq_q), .isr_q(isr_q),
        .route_valid_q(route_valid_q), .route_queue_q(route_queue_q), .tx_busy_q(tx_busy_q),
        .tx_abort_q(tx_abort_q));
    mii_phy_model phy (.mii_txd_q(mii_txd_q), .mii_tx_en_q(mii_tx_en_q), .carrier(carrier), .collide(collide),
        .mii_tx_clk(mii_tx_clk), .mii_crs(mii_crs), .mii_col(mii_col));
    initial begin
        forever #25 clock = ~clock;
    end
    task complete_run;
        begin
            if (failures == 0 && cmp_count > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("BAD %0t %0s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask
    task hang(input string what);
        begin
            failures = failures + 1;
            $display("BAD %0t timeout %0s", $time, what);
            complete_run;
        end
    endtask
    task t_events;
        begin
            @(posedge clock);
            prio_queue_en <= 1'b1;
            dma_event <= 4'h8;
            @(posedge clock);
            dma_event <= 4'h0;
            mac_event <= 1'b1;
            @(posedge clock);
            mac_event <= 1'b0;
            @(posedge clock);
            #1 chk(isr_q, 4'h9, "status per queue");
            chk(irq_q, 4'h9, "interrupt per queue");
            @(posedge clock);
            isr_clear <= 4'hF;
            prio_queue_en <= 1'b0;
            @(posedge clock);
            isr_clear <= 4'h0;
            dma_event <= 4'h4;
            @(posedge clock);
            dma_event <= 4'h0;
            @(posedge clock);
            #1 chk(isr_q, 4'h1, "single queue status");
            @(posedge clock);
            isr_clear <= 4'hF;
            @(posedge clock);
            isr_clear <= 4'h0;
        end
    endtask
    task send_rx(input [7:0] b2, input [7:0] b3, input m);
        integer i;
        begin
            @(posedge clock);
            rx_frame_start <= 1'b1;
            for (i = 0; i < 20; i = i + 1) begin
                @(posedge clock);
                rx_frame_start <= 1'b0;
                rx_byte_valid <= 1'b1;
                rx_byte <= (i == 2) ? b2 : (i == 3) ? b3 : i[7:0];
            end
            @(posedge clock);
            rx_byte_valid <= 1'b0;
            rx_frame_end <= 1'b1;
            rx_addr_match <= m;
            @(posedge clock);
            rx_frame_end <= 1'b0;
            #1;
        end
    endtask
    task t_screen;
        begin
            cw_position[35 +: 7] <= 7'h02;
            cw_value[80 +: 16] <= 16'hBEEF;
            cw_mask[80 +: 16] <= 16'hFFFF;
            cw_position[49 +: 7] <= 7'h0A;
            cw_value[112 +: 16] <= 16'h550A;
            cw_mask[112 +: 16] <= 16'h00FF;
            screen_en[2:0] <= 3'b011;
            screen_sel[14:0] <= {5'h00, 5'h07, 5'h05};
            screen_queue[1:0] <= 2'h3;
            send_rx(8'hEF, 8'hBE, 1'b1);
            chk({route_valid_q, route_queue_q}, 3'h7, "masked match");
            send_rx(8'hBE, 8'hEF, 1'b1);
            chk({route_valid_q, route_queue_q}, 3'h4, "byte order");
            send_rx(8'hEF, 8'hBE, 1'b0);
            chk(route_valid_q, 1'b0, "no address match");
        end
    endtask
    task push_word(input [31:0] w, input [1:0] nb, input l);
        integer n;
        begin
            tx_word_valid <= 1'b1;
            tx_word <= w;
            tx_word_bytes <= nb;
            tx_word_last <= l;
            n = 0;
            @(posedge clock);
            while (tx_word_ready_q !== 1'b1 && n < 4000) begin
                n = n + 1;
                @(posedge clock);
            end
            if (n == 4000) hang("word not taken");
        end
    endtask
    task t_tx(input fd);
        integer i, k, n;
        reg [7:0] exp [0:71];
        reg [31:0] crc;
        reg [31:0] tmp;
        reg ab;
        begin
            @(posedge clock);
            full_duplex <= fd;
            phy.rx_q.delete();
            ab = 1'b0;
            crc = 32'hFFFFFFFF;
            for (i = 0; i < 68; i = i + 1) begin
                tmp = 17 * (i - 7);
                exp[i] = (i < 7) ? 8'h55 : (i == 7) ? 8'hD5 : (i < 14) ? tmp[7:0] : 8'h00;
                for (k = 0; k < 8 && i > 7; k = k + 1) begin
                    crc = crc ^ ((k == 0) ? {24'h0, exp[i]} : 32'h0);
                    crc = crc[0] ? ((crc >> 1) ^ 32'hEDB88320) : (crc >> 1);
                end
            end
            crc = ~crc;
            for (i = 0; i < 4; i = i + 1) exp[68 + i] = crc[8 * i +: 8];
            push_word(32'h44332211, 2'h3, 1'b0);
            push_word(32'h00006655, 2'h1, 1'b1);
            tx_word_valid <= 1'b0;
            n = 0;
            while ((phy.rx_q.size() < 72 || mii_tx_en_q !== 1'b0) && n < 6000) begin
                n = n + 1;
                @(posedge clock);
                if (tx_abort_q === 1'b1) ab = 1'b1;
            end
            if (n == 6000) hang("frame not sent");
            chk(ab, 1'b0, "frame aborted");
            chk(phy.rx_q.size(), 72, "frame length");
            for (i = 0; i < 72; i = i + 1) chk(phy.rx_q[i], exp[i], "frame byte");
        end
    endtask
    task t_defer;
        reg seen;
        integer n;
        begin
            seen = 1'b0;
            carrier <= 1'b1;
            fork
                t_tx(1'b0);
                begin
                    repeat (300) begin
                        @(posedge clock);
                        if (mii_tx_en_q !== 1'b0) seen = 1'b1;
                    end
                    carrier <= 1'b0;
                    n = 0;
                    while (mii_tx_en_q !== 1'b1 && n < 400) begin
                        n = n + 1;
                        @(posedge clock);
                    end
                    collide <= 1'b1;
                    while (mii_tx_en_q !== 1'b0 && n < 800) begin
                        n = n + 1;
                        @(posedge clock);
                    end
                    collide <= 1'b0;
                    phy.rx_q.delete();
                    chk(n < 800, 1'b1, "no jam after collision");
                end
            join
            chk(seen, 1'b0, "sent under carrier");
        end
    endtask
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_events;
        t_screen;
        t_tx(1'b1);
        t_defer;
        complete_run;
    end
endmodule // tb
